/* hdl/fifo_ctl_pkg.sv */
/*
 * Constants for the serial port FIFO control block: register offsets, field
 * positions, reset values and control write masks.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
`default_nettype none

package fifo_ctl_pkg;

    // Register byte addresses.
    localparam logic [7:0] OFS_FIFO_CONTROL = 8'h00;
    localparam logic [7:0] OFS_FIFO_FILL_COUNT = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_DATA = 8'h10;

    // Control register fields.
    localparam int BIT_LOOP = 0;
    localparam int BIT_RX_FLUSH = 1;
    localparam int BIT_TX_FLUSH = 2;
    localparam int BIT_MCE = 3;
    localparam int POS_TX_TRIG = 4;
    localparam int POS_RX_TRIG = 6;
    localparam int POS_RTS_TRIG = 8;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_MASK_LATER = 16'h07FF;
    localparam logic [15:0] CTRL_MASK_EARLY = 16'h00FF;

    // Fill count layout.
    localparam int POS_TX_COUNT = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 5;
    localparam int PTR_W = 4;

    // Interrupt status bits.
    localparam int IRQ_RX_FULL = 0;
    localparam int IRQ_TX_EMPTY = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Data register: bit 8 reads receive-empty.
    localparam int BIT_RX_EMPTY = 8;

endpackage : fifo_ctl_pkg

`default_nettype wire

/* hdl/byte_fifo.sv */
/*
 * Sixteen-entry byte FIFO with a level flush and an exact fill count.
 * Assumes push and pop come from logic on the same clock.
 */
`default_nettype none

module byte_fifo
    import fifo_ctl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flush,
    input wire logic push,
    input wire logic [7:0] wdata,
    input wire logic pop,
    output logic [7:0] rdata,
    output logic [CNT_W-1:0] count
);

    logic [7:0] mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wptr_r;
    logic [PTR_W-1:0] rptr_r;
    logic [CNT_W-1:0] count_r;
    logic do_push;
    logic do_pop;

    // A push into a full FIFO or a pop from an empty one is dropped.
    assign do_push = push && (count_r != CNT_W'(FIFO_DEPTH)) && !flush;
    assign do_pop = pop && (count_r != '0) && !flush;
    assign rdata = mem[rptr_r];
    assign count = count_r;

    // Storage needs no reset; only the pointers define content.
    always_ff @(posedge pclk)
    begin
        if (do_push)
            mem[wptr_r] <= wdata;
    end

    // Pointers and count, held empty while the flush level stands.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
            count_r <= '0;
        end
        else if (flush)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (do_push)
                wptr_r <= wptr_r + 1'b1;
            if (do_pop)
                rptr_r <= rptr_r + 1'b1;
            if (do_push && !do_pop)
                count_r <= count_r + 1'b1;
            else if (do_pop && !do_push)
                count_r <= count_r - 1'b1;
        end
    end

endmodule // byte_fifo

`default_nettype wire

/* hdl/serial_fifo_trigger_control.sv */
/*
 * FIFO control, trigger flags, modem handshake and loopback routing of a
 * serial port with sixteen-entry transmit and receive FIFOs, on APB.
 * Assumes an external serializer that pops tx bytes and pushes rx bytes
 * on pclk; serial pins and clear-to-send arrive asynchronously.
 */
`default_nettype none

// Notes on behaviour
// - Control register resets to zero.
// - Control bits 15 to 11 read zero.
// - RTS high when rx count exceeds trigger.
// - Rx full flag when count reaches trigger.
// - Tx empty flag at or below trigger.
// - Earlier variant uses tx triggers 7,3,1,0.
// - Modem enable makes CTS and RTS functional.
// - Modem disabled: CTS asserted, RTS held low.
// - Tx flush bit empties transmit FIFO.
// - Rx flush bit empties receive FIFO.
// - Reset also empties both FIFOs.
// - Loopback routes tx to rx, RTS to CTS.
// - Fill counts at bits 12:8 and 4:0.
// - Counts read 0x00 empty, 0x10 full.
// - Control register accessible at any time.
module serial_fifo_trigger_control
    import fifo_ctl_pkg::*;
#(
    parameter bit EARLY_VARIANT = 1'b0
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_pop,
    output logic [7:0] tx_byte,
    output logic tx_byte_valid,
    input wire logic rx_push,
    input wire logic [7:0] rx_byte,
    input wire logic serial_line_tx,
    input wire logic serial_in_pin,
    input wire logic clear_to_send_line,
    output logic serial_out_pin,
    output logic request_to_send_line,
    output logic serial_in_to_core,
    output logic cts_active,
    output logic rx_full_flag,
    output logic tx_empty_flag,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Trigger decoding.

    // Rx full threshold from the two-bit code.
    function automatic logic [CNT_W-1:0] rx_trigger(input logic [1:0] code);
        case (code)
            2'h0: rx_trigger = 5'h01;
            2'h1: rx_trigger = 5'h04;
            2'h2: rx_trigger = 5'h08;
            default: rx_trigger = 5'h0E;
        endcase
    endfunction

    // Tx empty threshold; the earlier variant keeps one byte less.
    function automatic logic [CNT_W-1:0] tx_trigger(input logic [1:0] code, input logic early);
        case (code)
            2'h0: tx_trigger = early ? 5'h07 : 5'h08;
            2'h1: tx_trigger = early ? 5'h03 : 5'h04;
            2'h2: tx_trigger = early ? 5'h01 : 5'h02;
            default: tx_trigger = early ? 5'h00 : 5'h01;
        endcase
    endfunction

    // RTS threshold from the three-bit code; code zero means fifteen.
    function automatic logic [CNT_W-1:0] rts_trigger(input logic [2:0] code);
        case (code)
            3'h0: rts_trigger = 5'h0F;
            3'h1: rts_trigger = 5'h01;
            3'h2: rts_trigger = 5'h04;
            3'h3: rts_trigger = 5'h06;
            3'h4: rts_trigger = 5'h08;
            3'h5: rts_trigger = 5'h0A;
            3'h6: rts_trigger = 5'h0C;
            default: rts_trigger = 5'h0E;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers and APB decode.

    logic [15:0] fifo_control_r;
    logic [1:0] irq_status_r;
    logic [1:0] irq_mask_r;
    logic [15:0] ctrl_mask;
    logic wr_en;
    logic rd_en;
    logic tx_flush;
    logic rx_flush;
    logic modem_control_enable;
    logic loop_en;
    logic [CNT_W-1:0] tx_count;
    logic [CNT_W-1:0] rx_count;
    logic [7:0] rx_head;
    logic [7:0] tx_head;
    logic rx_read_pop;
    logic tx_write_push;
    logic rx_full_now;
    logic tx_empty_now;
    logic rx_full_d;
    logic tx_empty_d;
    logic [1:0] irq_events;

    assign ctrl_mask = EARLY_VARIANT ? CTRL_MASK_EARLY : CTRL_MASK_LATER;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign tx_flush = fifo_control_r[BIT_TX_FLUSH];
    assign rx_flush = fifo_control_r[BIT_RX_FLUSH];
    assign modem_control_enable = fifo_control_r[BIT_MCE];
    assign loop_en = fifo_control_r[BIT_LOOP];
    assign rx_read_pop = rd_en && (paddr == OFS_DATA);
    assign tx_write_push = wr_en && (paddr == OFS_DATA);

    // Control register; writable in every state, no activity interlock.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fifo_control_r <= CTRL_RESET;
        else if (wr_en && paddr == OFS_FIFO_CONTROL)
            fifo_control_r <= pwdata[15:0] & ctrl_mask;
    end

    // Interrupt mask.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_r <= IRQ_RESET;
        else if (wr_en && paddr == OFS_IRQ_MASK)
            irq_mask_r <= pwdata[1:0];
    end

    // Every access completes in one access cycle, so pready is held high.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            pslverr <= 1'b0;
        end
    end

    // Read data is registered during setup so it is valid in access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                OFS_FIFO_CONTROL: prdata <= {16'h0000, fifo_control_r};
                OFS_FIFO_FILL_COUNT: prdata <= {19'h00000, tx_count, 3'h0, rx_count};
                OFS_IRQ_STATUS: prdata <= {30'h00000000, irq_status_r};
                OFS_IRQ_MASK: prdata <= {30'h00000000, irq_mask_r};
                OFS_DATA: prdata <= {23'h000000, rx_count == '0, rx_head};
                default: prdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // FIFOs.

    // Reset and the flush levels both clear the FIFOs.
    byte_fifo u_tx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(tx_flush),
        .push(tx_write_push),
        .wdata(pwdata[7:0]),
        .pop(tx_pop),
        .rdata(tx_head),
        .count(tx_count)
    );

    byte_fifo u_rx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(rx_flush),
        .push(rx_push),
        .wdata(rx_byte),
        .pop(rx_read_pop),
        .rdata(rx_head),
        .count(rx_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Flags and interrupt.

    assign rx_full_now = rx_count >= rx_trigger(fifo_control_r[POS_RX_TRIG +: 2]);
    assign tx_empty_now = tx_count <= tx_trigger(fifo_control_r[POS_TX_TRIG +: 2], EARLY_VARIANT);

    // Flag outputs and edge history, registered.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_full_flag <= 1'b0;
            tx_empty_flag <= 1'b0;
            rx_full_d <= 1'b0;
            tx_empty_d <= 1'b0;
            tx_byte <= '0;
            tx_byte_valid <= 1'b0;
        end
        else
        begin
            rx_full_flag <= rx_full_now;
            tx_empty_flag <= tx_empty_now;
            rx_full_d <= rx_full_flag;
            tx_empty_d <= tx_empty_flag;
            tx_byte <= tx_head;
            tx_byte_valid <= (tx_count != '0) && !tx_flush;
        end
    end

    // Rising edges of the flags are the interrupt events.
    assign irq_events = {tx_empty_flag && !tx_empty_d, rx_full_flag && !rx_full_d};

    // Sticky status; a read clears only the bits it reported, so an event that lands
    // between setup and access is kept, and a new event in the clearing cycle wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status_r <= IRQ_RESET;
        else if (rd_en && paddr == OFS_IRQ_STATUS)
            irq_status_r <= (irq_status_r & ~prdata[1:0]) | irq_events;
        else
            irq_status_r <= irq_status_r | irq_events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_status_r & irq_mask_r);
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins, handshake and loopback.

    logic rxd_s1;
    logic rxd_s2;
    logic cts_s1;
    logic cts_s2;
    logic rts_level;

    // Two-stage synchronisers for the asynchronous pin inputs.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            cts_s1 <= 1'b0;
            cts_s2 <= 1'b0;
        end
        else
        begin
            rxd_s1 <= serial_in_pin;
            rxd_s2 <= rxd_s1;
            cts_s1 <= clear_to_send_line;
            cts_s2 <= cts_s1;
        end
    end

    // RTS rises when received data exceed the trigger, only under modem control.
    assign rts_level = modem_control_enable && (rx_count > rts_trigger(EARLY_VARIANT ? 3'h0 :
                       fifo_control_r[POS_RTS_TRIG +: 3]));

    // Loopback keeps the line idle high so the far end sees no traffic.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_out_pin <= 1'b1;
            request_to_send_line <= 1'b0;
            serial_in_to_core <= 1'b1;
            cts_active <= 1'b1;
        end
        else
        begin
            serial_out_pin <= loop_en ? 1'b1 : serial_line_tx;
            request_to_send_line <= loop_en ? 1'b0 : rts_level;
            serial_in_to_core <= loop_en ? serial_line_tx : rxd_s2;
            // CTS is active low; without modem control it is forced active.
            cts_active <= !modem_control_enable ? 1'b1 : (loop_en ? !rts_level : !cts_s2);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_flush_set;
        $rose(fifo_control_r[BIT_TX_FLUSH]);
    endsequence

    chk_reset_ctrl: assert property (@(posedge pclk) $rose(presetn) |-> fifo_control_r == CTRL_RESET)
        else $error("control not zero after reset");
    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) fifo_control_r[15:11] == 5'h00)
        else $error("reserved control bits set");
    chk_early_zero: assert property (@(posedge pclk) disable iff (!presetn)
        EARLY_VARIANT |-> fifo_control_r[10:8] == 3'h0)
        else $error("early variant rts field set");
    chk_rx_full: assert property (@(posedge pclk) disable iff (!presetn) rx_full_flag == $past(rx_full_now))
        else $error("rx full flag mismatch");
    chk_tx_empty: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_count == '0) |=> tx_empty_flag)
        else $error("tx empty flag missing");
    chk_rts_off: assert property (@(posedge pclk) disable iff (!presetn)
        !modem_control_enable |=> !request_to_send_line && cts_active)
        else $error("modem lines not forced");
    chk_tx_flush: assert property (@(posedge pclk) disable iff (!presetn) s_flush_set |=> tx_count == '0)
        else $error("tx flush did not empty");
    chk_rx_flush_hold: assert property (@(posedge pclk) disable iff (!presetn)
        rx_flush ##1 rx_flush |-> rx_count == '0)
        else $error("rx fifo not held empty");
    chk_count_range: assert property (@(posedge pclk) disable iff (!presetn)
        tx_count <= 5'h10 && rx_count <= 5'h10)
        else $error("fill count beyond sixteen");
    chk_loop_rx: assert property (@(posedge pclk) disable iff (!presetn)
        loop_en |=> serial_in_to_core == $past(serial_line_tx))
        else $error("loopback data not routed");
    chk_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_events != 2'h0) |=> (irq_status_r & $past(irq_events)) == $past(irq_events))
        else $error("interrupt event lost");

endmodule // serial_fifo_trigger_control

`default_nettype wire

/* tb/serial_peer.sv */
/*
 * Remote serial device at the far end of the port's pins.
 * Assumes the bench sets its pause request and data level at clock edges.
 */
`default_nettype none

module serial_peer
(
    input wire logic rts_line,
    input wire logic hold_off,
    input wire logic rx_level,
    output logic cts_n,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;

    // A high clear-to-send pauses us; the line idles high while we ask the peer to stop.
    assign cts_n = hold_off;
    assign rxd = rts_line ? 1'b1 : rx_level;
endmodule // serial_peer

`default_nettype wire

/* tb/serial_fifo_trigger_control_bench.sv */
/*
 * Self-checking bench: APB tasks, trigger tables and pin scenarios.
 * Assumes the package, the design and the peer model are compiled first.
 */
`default_nettype none

module serial_fifo_trigger_control_bench
    import fifo_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, use_e = 1'b0;
    logic [7:0] paddr = 8'h00, rx_byte = 8'h00, tx_byte;
    logic [31:0] pwdata = 32'h0, prdata, prdata_e, q;
    logic tx_pop = 1'b0, rx_push = 1'b0, serial_line_tx = 1'b1, hold_off = 1'b0, rx_level = 1'b1;
    logic pready, pslverr, tx_byte_valid, serial_in_pin, clear_to_send_line, serial_out_pin, rts, rts_e;
    logic serial_in_to_core, cts_active, rx_full_flag, tx_empty_flag, txe_e, irq;
    int n_mismatch = 0, checks = 0, cycles = 0, m;
    logic [15:0] c;
    int rx_t[4] = '{1, 4, 8, 14};
    int tx_t[4] = '{8, 4, 2, 1};
    int txe_t[4] = '{7, 3, 1, 0};
    int rts_t[8] = '{15, 1, 4, 6, 8, 10, 12, 14};

    // The later variant is the main subject; the earlier one shares every input.
    serial_fifo_trigger_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_pop(tx_pop), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .rx_push(rx_push), .rx_byte(rx_byte),
        .serial_line_tx(serial_line_tx), .serial_in_pin(serial_in_pin), .clear_to_send_line(clear_to_send_line),
        .serial_out_pin(serial_out_pin), .request_to_send_line(rts), .serial_in_to_core(serial_in_to_core),
        .cts_active(cts_active), .rx_full_flag(rx_full_flag), .tx_empty_flag(tx_empty_flag), .irq(irq));
    serial_fifo_trigger_control #(.EARLY_VARIANT(1'b1)) i_dut_early (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_e),
        .pready(), .pslverr(), .tx_pop(tx_pop), .tx_byte(), .tx_byte_valid(), .rx_push(rx_push),
        .rx_byte(rx_byte), .serial_line_tx(serial_line_tx), .serial_in_pin(serial_in_pin),
        .clear_to_send_line(clear_to_send_line), .serial_out_pin(), .request_to_send_line(rts_e),
        .serial_in_to_core(), .cts_active(), .rx_full_flag(), .tx_empty_flag(txe_e), .irq());
    serial_peer i_peer (.rts_line(rts), .hold_off(hold_off), .rx_level(rx_level), .cts_n(clear_to_send_line),
        .rxd(serial_in_pin));

    // Clock at 20 MHz.
    always #25 pclk = ~pclk;

    // A hang is cut short well beyond the roughly 1700 cycles the run needs.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and bus tasks.
    task automatic close_out();
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; read data is taken at the edge where pready is seen.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = use_e ? prdata_e : prdata;
        check("pslverr", pslverr, 1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic push_rx(input logic [7:0] d);
        @(posedge pclk);
        rx_push <= 1'b1;
        rx_byte <= d;
        @(posedge pclk);
        rx_push <= 1'b0;
    endtask

    // Waits whole cycles, then steps past the edge so registered outputs have settled.
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_FIFO_CONTROL, 0); check("control", q, 32'h0);
        apb(0, OFS_FIFO_FILL_COUNT, 0); check("fill", q, 32'h0);
        apb(1, OFS_FIFO_CONTROL, 32'hFFFF);
        apb(0, OFS_FIFO_CONTROL, 0); check("control", q, 32'h07FF);
        use_e = 1'b1;
        apb(0, OFS_FIFO_CONTROL, 0); check("control early", q, 32'h00FF);
        use_e = 1'b0;
        apb(0, 8'h20, 0); check("unmapped", q, 32'h0);
        // Every trigger code, with both FIFOs filled one entry at a time past full.
        for (int k = 0; k < 8; k++)
        begin
            c = 16'h0008 | 16'(k << 8) | 16'((k % 4) * 'h50);
            apb(1, OFS_FIFO_CONTROL, {16'h0, c | 16'h0006});
            apb(0, OFS_FIFO_FILL_COUNT, 0); check("flushed", q, 32'h0);
            apb(1, OFS_FIFO_CONTROL, {16'h0, c});
            for (int n = 1; n <= 17; n++)
            begin
                push_rx(8'(n));
                apb(1, OFS_DATA, n);
                idle(3);
                apb(0, OFS_FIFO_FILL_COUNT, 0);
                m = n > 16 ? 16 : n;
                check("fill", q, (m << 8) | m);
                check("rx full", rx_full_flag, m >= rx_t[k % 4]);
                check("tx empty", tx_empty_flag, m <= tx_t[k % 4]);
                check("tx empty early", txe_e, m <= txe_t[k % 4]);
                check("rts", rts, m > rts_t[k]);
                check("rts early", rts_e, m > 15);
            end
        end
        check("tx head", {tx_byte_valid, tx_byte}, 9'h101);
        @(posedge pclk);
        tx_pop <= 1'b1;
        @(posedge pclk);
        tx_pop <= 1'b0;
        idle(3);
        check("tx next", tx_byte, 8'h02);
        apb(0, OFS_DATA, 0); check("rx head", q[8:0], 9'h001);
        apb(0, OFS_FIFO_FILL_COUNT, 0); check("after pops", q, 32'h0F0F);
        // A reset in mid-run empties both FIFOs and clears control.
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_FIFO_CONTROL, 0); check("control", q, 32'h0);
        apb(0, OFS_FIFO_FILL_COUNT, 0); check("fill", q, 32'h0);
        apb(0, OFS_IRQ_STATUS, 0); check("status reset", q[1:0], 2'h2);
        // Flush bits held high keep both FIFOs empty.
        apb(1, OFS_FIFO_CONTROL, 32'h6);
        push_rx(8'h55);
        apb(1, OFS_DATA, 32'h55);
        idle(3);
        apb(0, OFS_FIFO_FILL_COUNT, 0); check("held", q, 32'h0);
        check("tx valid", tx_byte_valid, 1'b0);
        apb(1, OFS_FIFO_CONTROL, 32'h0);
        push_rx(8'h55);
        apb(1, OFS_DATA, 32'h55);
        apb(0, OFS_FIFO_FILL_COUNT, 0); check("resumed", q, 32'h0101);
        // Modem handshake off and on, with the peer pausing us.
        push_rx(8'h66);
        hold_off <= 1'b1;
        apb(1, OFS_FIFO_CONTROL, 32'h0100);
        idle(5);
        check("rts off", rts, 1'b0);
        check("cts off", cts_active, 1'b1);
        apb(1, OFS_FIFO_CONTROL, 32'h0108);
        idle(5);
        check("rts on", rts, 1'b1);
        check("cts on", cts_active, 1'b0);
        @(posedge pclk);
        hold_off <= 1'b0;
        idle(5);
        check("cts clear", cts_active, 1'b1);
        // Loopback against the pin path.
        @(posedge pclk);
        serial_line_tx <= 1'b0;
        apb(1, OFS_FIFO_CONTROL, 32'h0109);
        idle(5);
        check("loop in", serial_in_to_core, 1'b0);
        check("loop out", serial_out_pin, 1'b1);
        check("loop rts", rts, 1'b0);
        check("loop cts", cts_active, 1'b0);
        // Levels opposite to the looped ones show that the pins are back in use.
        apb(1, OFS_FIFO_CONTROL, 32'h0100);
        idle(5);
        check("line in", serial_in_to_core, 1'b1);
        check("line out", serial_out_pin, 1'b0);
        // Receive-full interrupt: raised, then masked, then cleared by reading status.
        for (int k = 1; k >= 0; k--)
        begin
            apb(1, OFS_IRQ_MASK, k);
            apb(1, OFS_FIFO_CONTROL, 32'h2);
            apb(1, OFS_FIFO_CONTROL, 32'h0);
            apb(0, OFS_IRQ_STATUS, 0);
            push_rx(8'h77);
            idle(3);
            check("irq", irq, k);
        end
        apb(0, OFS_IRQ_STATUS, 0); check("status", q[1:0], 2'h1);
        apb(1, OFS_IRQ_MASK, 1);
        idle(2);
        check("irq cleared", irq, 1'b0);
        close_out();
    end
endmodule // serial_fifo_trigger_control_bench

`default_nettype wire
